// ===== hw/dpram_port.sv
`include "dpram_map.svh"
`default_nettype none
module dpram_port
  import dpram_pkg::*;
#(
  parameter int ADDR_W = `DPRAM_ADDR_W_DEFAULT,
  parameter int DATA_W = `DPRAM_DATA_W_DEFAULT,
  parameter int LOW_W = `DPRAM_LOW_LANE_W18
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic address_strobe_n,
  input wire logic burst_count_enable_n,
  input wire logic burst_count_clear_n,
  input wire logic chip_select_low_active,
  input wire logic chip_select_high_active,
  input wire logic write_n,
  input wire logic lower_lane_select_n,
  input wire logic upper_lane_select_n,
  input wire logic output_enable_n,
  input wire logic output_mode_select,
  input wire logic [DATA_W-1:0] data_in,
  output logic [DATA_W-1:0] data_out,
  output logic [DATA_W-1:0] data_oe,
  output logic [ADDR_W-1:0] mem_addr,
  output logic mem_we_low,
  output logic mem_we_high,
  output logic [DATA_W-1:0] mem_wdata,
  input wire logic [DATA_W-1:0] mem_rdata,
  output logic powered_down
);
  count_op_t op;
  logic [ADDR_W-1:0] count_r, count_nxt;
  logic sel_r, sel_nxt;
  logic rd_r, rd_nxt;
  logic rd_pipe_r, rd_pipe_nxt;
  logic lo_r, lo_nxt, hi_r, hi_nxt;
  logic lo_pipe_r, lo_pipe_nxt, hi_pipe_r, hi_pipe_nxt;
  logic mode_r, mode_nxt;
  logic we_low_r, we_low_nxt, we_high_r, we_high_nxt;
  logic [DATA_W-1:0] wdata_r, wdata_nxt;
  logic [DATA_W-1:0] pipe_r, pipe_nxt;
  logic sel_in;
  logic drive_lo, drive_hi;
  logic [DATA_W-1:0] rsel;

  // Lane split must leave both lanes non-empty
  if (LOW_W < 1 || LOW_W >= DATA_W) begin : g_bad_lane
    $error("LOW_W must leave an upper lane");
  end

  assign sel_in = !chip_select_low_active && chip_select_high_active;

  always_comb begin
    // Clear first, then load, then increment, else hold; select plays no part
    if (!burst_count_clear_n) begin
      op = cnt_clear;
    end else if (!address_strobe_n) begin
      op = cnt_load;
    end else if (!burst_count_enable_n) begin
      op = cnt_incr;
    end else begin
      op = cnt_hold;
    end
    unique case (op)
      cnt_clear: count_nxt = ADDR_W'(`DPRAM_COUNT_ZERO);
      cnt_load: count_nxt = addr;
      cnt_incr: count_nxt = count_r + ADDR_W'(1);
      cnt_hold: count_nxt = count_r;
    endcase
    sel_nxt = sel_in;
    rd_nxt = sel_in && write_n;
    lo_nxt = !lower_lane_select_n;
    hi_nxt = !upper_lane_select_n;
    we_low_nxt = sel_in && !write_n && !lower_lane_select_n;
    we_high_nxt = sel_in && !write_n && !upper_lane_select_n;
    wdata_nxt = data_in;
    mode_nxt = output_mode_select;
    // Pipelined stage captures the flow-through word one cycle later
    pipe_nxt = mem_rdata;
    rd_pipe_nxt = rd_r;
    lo_pipe_nxt = lo_r;
    hi_pipe_nxt = hi_r;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      count_r <= '0;
      sel_r <= 1'b0;
      rd_r <= 1'b0;
      rd_pipe_r <= 1'b0;
      lo_r <= 1'b0;
      hi_r <= 1'b0;
      lo_pipe_r <= 1'b0;
      hi_pipe_r <= 1'b0;
      mode_r <= 1'b0;
      we_low_r <= 1'b0;
      we_high_r <= 1'b0;
      wdata_r <= '0;
      pipe_r <= '0;
    end else begin
      count_r <= count_nxt;
      sel_r <= sel_nxt;
      rd_r <= rd_nxt;
      rd_pipe_r <= rd_pipe_nxt;
      lo_r <= lo_nxt;
      hi_r <= hi_nxt;
      lo_pipe_r <= lo_pipe_nxt;
      hi_pipe_r <= hi_pipe_nxt;
      mode_r <= mode_nxt;
      we_low_r <= we_low_nxt;
      we_high_r <= we_high_nxt;
      wdata_r <= wdata_nxt;
      pipe_r <= pipe_nxt;
    end
  end

  // Access goes to the counter, which tracks load/increment/clear
  assign mem_addr = count_r;
  assign mem_we_low = we_low_r;
  assign mem_we_high = we_high_r;
  assign mem_wdata = wdata_r;
  assign powered_down = !sel_r;

  always_comb begin
    // Output enable acts without the clock
    if (mode_r) begin
      drive_lo = rd_pipe_r && lo_pipe_r && !output_enable_n;
      drive_hi = rd_pipe_r && hi_pipe_r && !output_enable_n;
      rsel = pipe_r;
    end else begin
      drive_lo = rd_r && lo_r && !output_enable_n;
      drive_hi = rd_r && hi_r && !output_enable_n;
      rsel = mem_rdata;
    end
    data_out = rsel;
    data_oe = {{(DATA_W-LOW_W){drive_hi}}, {LOW_W{drive_lo}}};
  end
endmodule
`default_nettype wire

// ===== hw/dpram_map.svh
`ifndef DPRAM_MAP_SVH
`define DPRAM_MAP_SVH
`define DPRAM_DEPTH_DEFAULT 65536
`define DPRAM_ADDR_W_DEFAULT 16
`define DPRAM_DATA_W_DEFAULT 18
`define DPRAM_LOW_LANE_W18 9
`define DPRAM_LOW_LANE_W16 8
`define DPRAM_COUNT_ZERO 0
`endif

// ===== hw/dpram_pkg.sv
`default_nettype none
package dpram_pkg;
  typedef enum logic [1:0] {
    cnt_hold = 2'b00,
    cnt_load = 2'b01,
    cnt_incr = 2'b10,
    cnt_clear = 2'b11
  } count_op_t;
endpackage
`default_nettype wire

// ===== hw/dpram_store.sv
`include "dpram_map.svh"
`default_nettype none
module dpram_store #(
  parameter int ADDR_W = `DPRAM_ADDR_W_DEFAULT,
  parameter int DATA_W = `DPRAM_DATA_W_DEFAULT,
  parameter int LOW_W = `DPRAM_LOW_LANE_W18
) (
  input wire logic clk,
  input wire logic a_we_low,
  input wire logic a_we_high,
  input wire logic [ADDR_W-1:0] a_addr,
  input wire logic [DATA_W-1:0] a_wdata,
  output logic [DATA_W-1:0] a_rdata,
  input wire logic b_we_low,
  input wire logic b_we_high,
  input wire logic [ADDR_W-1:0] b_addr,
  input wire logic [DATA_W-1:0] b_wdata,
  output logic [DATA_W-1:0] b_rdata
);
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

  // Word write completes within the cycle it is presented
  always_ff @(posedge clk) begin
    if (a_we_low) begin
      mem[a_addr][LOW_W-1:0] <= a_wdata[LOW_W-1:0];
    end
    if (a_we_high) begin
      mem[a_addr][DATA_W-1:LOW_W] <= a_wdata[DATA_W-1:LOW_W];
    end
    if (b_we_low) begin
      mem[b_addr][LOW_W-1:0] <= b_wdata[LOW_W-1:0];
    end
    if (b_we_high) begin
      mem[b_addr][DATA_W-1:LOW_W] <= b_wdata[DATA_W-1:LOW_W];
    end
  end

  // Combinational read; output register lives in the port logic
  always_comb begin
    a_rdata = mem[a_addr];
    b_rdata = mem[b_addr];
  end
endmodule
`default_nettype wire

// ===== hw/dpram_top.sv
// What this block does
// - Two ports access any location simultaneously
// - Depth 16K/32K/64K with matching address width
// - Inputs except output enable registered on rising clock edge
// - Select needs low select low, high high
// - Strobe low loads counter from address
// - Enable low increments, unless strobe/clear low
// - Clear low zeroes counter, highest priority
// - Separate counter per port, independent
// - One word per clock at counter address
// - Counter spans array, wraps to zero
// - Write low writes, high reads
// - Lower select gates lower lane
// - Upper select gates upper lane
// - Lane driven only with select and enable
// - Data driven on reads only with enable
// - Mode low flow-through, high pipelined
// - Flow-through data without extra register
// - Deselected cycle puts port in low power
// - Pipelined needs one selected cycle to reactivate
// - Write self-timed, done within one cycle
// - Strobe, enable, clear high holds counter
// - Pipelined data one cycle after flow-through
// - Output enable acts without the clock
// - Counter works regardless of selects
`include "dpram_map.svh"
`default_nettype none
module dpram_top
  import dpram_pkg::*;
#(
  parameter int DEPTH = `DPRAM_DEPTH_DEFAULT,
  parameter int DATA_W = `DPRAM_DATA_W_DEFAULT
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [$clog2(DEPTH)-1:0] a_addr,
  input wire logic a_address_strobe_n,
  input wire logic a_burst_count_enable_n,
  input wire logic a_burst_count_clear_n,
  input wire logic a_chip_select_low_active,
  input wire logic a_chip_select_high_active,
  input wire logic a_write_n,
  input wire logic a_lower_lane_select_n,
  input wire logic a_upper_lane_select_n,
  input wire logic a_output_enable_n,
  input wire logic a_output_mode_select,
  input wire logic [DATA_W-1:0] a_data_in,
  output logic [DATA_W-1:0] a_data_out,
  output logic [DATA_W-1:0] a_data_oe,
  output logic a_powered_down,
  input wire logic [$clog2(DEPTH)-1:0] b_addr,
  input wire logic b_address_strobe_n,
  input wire logic b_burst_count_enable_n,
  input wire logic b_burst_count_clear_n,
  input wire logic b_chip_select_low_active,
  input wire logic b_chip_select_high_active,
  input wire logic b_write_n,
  input wire logic b_lower_lane_select_n,
  input wire logic b_upper_lane_select_n,
  input wire logic b_output_enable_n,
  input wire logic b_output_mode_select,
  input wire logic [DATA_W-1:0] b_data_in,
  output logic [DATA_W-1:0] b_data_out,
  output logic [DATA_W-1:0] b_data_oe,
  output logic b_powered_down
);
  localparam int ADDR_W = $clog2(DEPTH);
  localparam int LOW_W = (DATA_W == 18) ? `DPRAM_LOW_LANE_W18 : `DPRAM_LOW_LANE_W16;

  // Only the documented organisations are served
  if (!(DEPTH == 16384 || DEPTH == 32768 || DEPTH == 65536)) begin : g_bad_depth
    $error("DEPTH must be 16K, 32K or 64K");
  end
  if (!(DATA_W == 16 || DATA_W == 18)) begin : g_bad_width
    $error("DATA_W must be 16 or 18");
  end

  logic [ADDR_W-1:0] a_mem_addr, b_mem_addr;
  logic a_we_low, a_we_high, b_we_low, b_we_high;
  logic [DATA_W-1:0] a_wdata, b_wdata, a_rdata, b_rdata;

  dpram_port #(.ADDR_W(ADDR_W), .DATA_W(DATA_W), .LOW_W(LOW_W)) u_port_a (
    .clk(clk), .rst(rst), .addr(a_addr),
    .address_strobe_n(a_address_strobe_n),
    .burst_count_enable_n(a_burst_count_enable_n),
    .burst_count_clear_n(a_burst_count_clear_n),
    .chip_select_low_active(a_chip_select_low_active),
    .chip_select_high_active(a_chip_select_high_active),
    .write_n(a_write_n),
    .lower_lane_select_n(a_lower_lane_select_n),
    .upper_lane_select_n(a_upper_lane_select_n),
    .output_enable_n(a_output_enable_n),
    .output_mode_select(a_output_mode_select),
    .data_in(a_data_in), .data_out(a_data_out), .data_oe(a_data_oe),
    .mem_addr(a_mem_addr), .mem_we_low(a_we_low), .mem_we_high(a_we_high),
    .mem_wdata(a_wdata), .mem_rdata(a_rdata), .powered_down(a_powered_down)
  );

  dpram_port #(.ADDR_W(ADDR_W), .DATA_W(DATA_W), .LOW_W(LOW_W)) u_port_b (
    .clk(clk), .rst(rst), .addr(b_addr),
    .address_strobe_n(b_address_strobe_n),
    .burst_count_enable_n(b_burst_count_enable_n),
    .burst_count_clear_n(b_burst_count_clear_n),
    .chip_select_low_active(b_chip_select_low_active),
    .chip_select_high_active(b_chip_select_high_active),
    .write_n(b_write_n),
    .lower_lane_select_n(b_lower_lane_select_n),
    .upper_lane_select_n(b_upper_lane_select_n),
    .output_enable_n(b_output_enable_n),
    .output_mode_select(b_output_mode_select),
    .data_in(b_data_in), .data_out(b_data_out), .data_oe(b_data_oe),
    .mem_addr(b_mem_addr), .mem_we_low(b_we_low), .mem_we_high(b_we_high),
    .mem_wdata(b_wdata), .mem_rdata(b_rdata), .powered_down(b_powered_down)
  );

  // No arbitration: on same-word writes from both ports, port B's write lands last and wins for each lane both write
  dpram_store #(.ADDR_W(ADDR_W), .DATA_W(DATA_W), .LOW_W(LOW_W)) u_store (
    .clk(clk),
    .a_we_low(a_we_low), .a_we_high(a_we_high), .a_addr(a_mem_addr),
    .a_wdata(a_wdata), .a_rdata(a_rdata),
    .b_we_low(b_we_low), .b_we_high(b_we_high), .b_addr(b_mem_addr),
    .b_wdata(b_wdata), .b_rdata(b_rdata)
  );
endmodule
`default_nettype wire

// ===== verif/dpram_monitor.sv
`default_nettype none
module dpram_monitor #(
  parameter int DATA_W = 18
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic a_chip_select_low_active,
  input wire logic a_chip_select_high_active,
  input wire logic a_write_n,
  input wire logic a_lower_lane_select_n,
  input wire logic a_upper_lane_select_n,
  input wire logic a_output_enable_n,
  input wire logic a_output_mode_select,
  input wire logic [DATA_W-1:0] a_data_oe,
  input wire logic a_powered_down,
  input wire logic b_chip_select_low_active,
  input wire logic b_chip_select_high_active,
  input wire logic b_powered_down
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int LOW_W = (DATA_W == 18) ? 9 : 8;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  wire logic a_sel = !a_chip_select_low_active && a_chip_select_high_active;
  wire logic b_sel = !b_chip_select_low_active && b_chip_select_high_active;
  sequence a_read_s;
    a_sel && a_write_n && !a_lower_lane_select_n && !a_upper_lane_select_n;
  endsequence
  sequence a_pipe_s;
    a_read_s ##0 a_output_mode_select;
  endsequence
  a_reset_quiet: assert property ($fell(rst) |-> a_data_oe == '0 && a_powered_down)
    else $error("port a not quiet after reset");
  a_desel_sleep: assert property (!a_sel |=> a_powered_down)
    else $error("port a not asleep after deselect");
  a_sel_wake: assert property (a_sel |=> !a_powered_down)
    else $error("port a asleep while selected");
  a_oe_gate: assert property (a_output_enable_n |-> a_data_oe == '0)
    else $error("port a drives with output enable off");
  a_write_quiet: assert property (a_sel && !a_write_n && !a_output_mode_select
    |=> a_data_oe == '0)
    else $error("port a drives after a write");
  a_lane_gate: assert property (a_lower_lane_select_n && !a_output_mode_select
    |=> a_data_oe[LOW_W-1:0] == '0)
    else $error("port a drives an unselected lower lane");
  a_flow_drive: assert property ((a_read_s ##0 !a_output_mode_select)
    |=> a_output_enable_n || &a_data_oe)
    else $error("port a flow read not driven");
  // Pipelined output follows the mode captured one edge before the check
  a_pipe_drive: assert property (a_pipe_s ##1 a_pipe_s ##1 a_output_mode_select
    |=> (a_output_enable_n || &a_data_oe))
    else $error("port a pipelined read not driven");
  // Deselect edge empties the output stage one edge later
  a_pipe_desel: assert property ((!a_sel && a_output_mode_select) ##1 a_output_mode_select
    |=> a_data_oe == '0)
    else $error("port a pipelined deselect still drives");
  a_b_sleep: assert property (!b_sel |=> b_powered_down)
    else $error("port b not asleep after deselect");
endmodule
bind dpram_top dpram_monitor #(.DATA_W(DATA_W)) mon (
  .clk(clk), .rst(rst), .a_chip_select_low_active(a_chip_select_low_active),
  .a_chip_select_high_active(a_chip_select_high_active), .a_write_n(a_write_n),
  .a_lower_lane_select_n(a_lower_lane_select_n),
  .a_upper_lane_select_n(a_upper_lane_select_n), .a_output_enable_n(a_output_enable_n),
  .a_output_mode_select(a_output_mode_select), .a_data_oe(a_data_oe),
  .a_powered_down(a_powered_down), .b_chip_select_low_active(b_chip_select_low_active),
  .b_chip_select_high_active(b_chip_select_high_active), .b_powered_down(b_powered_down)
);
`default_nettype wire

// ===== verif/b_host.sv
`default_nettype none
module b_host (
  input wire logic clk,
  input wire logic [1:0] op,
  input wire logic [13:0] a,
  input wire logic [17:0] d,
  output logic [13:0] addr = '0,
  output logic strobe_n = 1'b1,
  output logic write_n = 1'b1,
  output logic [17:0] data = '0
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] op_s;
  // One access per request, idle lines keep moving
  always @(posedge clk) begin
    op_s = op;
    #1;
    strobe_n = (op_s == 2'd0);
    write_n = (op_s != 2'd1);
    addr = (op_s != 2'd0) ? a : ~addr;
    data = (op_s == 2'd1) ? d : ~data;
  end
endmodule
`default_nettype wire

// ===== verif/dpram_top_tb.sv
`default_nettype none
module dpram_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic [13:0] adr; logic [17:0] dat;} row_t;
  localparam logic L = 1'b0;
  localparam logic H = 1'b1;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic stb_n = 1'b1, en_n = 1'b1, clr_n = 1'b1, cs_lo = 1'b0, cs_hi = 1'b1, wr_n = 1'b1;
  logic lo_n = 1'b0, hi_n = 1'b0, oe_n = 1'b0, mode = 1'b0;
  logic [13:0] adr = '0;
  logic [17:0] din = '0;
  logic [1:0] bop = '0;
  logic [17:0] a_dout, a_oe, b_dout, b_din, b_oe;
  logic a_pd, b_pd, b_stb, b_wr;
  logic [13:0] b_adr;
  int fails = 0, n_compared = 0;
  row_t rows [4] = '{'{14'h0000, 18'h00001}, '{14'h3fff, 18'h3ffff},
                     '{14'h1234, 18'h2a5c3}, '{14'h0007, 18'h10f0e}};
  always #5 clk = ~clk;
  dpram_top #(.DEPTH(16384), .DATA_W(18)) uut (
    .clk(clk), .rst(rst), .a_addr(adr), .a_address_strobe_n(stb_n),
    .a_burst_count_enable_n(en_n), .a_burst_count_clear_n(clr_n),
    .a_chip_select_low_active(cs_lo), .a_chip_select_high_active(cs_hi), .a_write_n(wr_n),
    .a_lower_lane_select_n(lo_n), .a_upper_lane_select_n(hi_n), .a_output_enable_n(oe_n),
    .a_output_mode_select(mode), .a_data_in(din), .a_data_out(a_dout), .a_data_oe(a_oe),
    .a_powered_down(a_pd), .b_addr(b_adr), .b_address_strobe_n(b_stb),
    .b_burst_count_enable_n(en_n), .b_burst_count_clear_n(clr_n),
    .b_chip_select_low_active(cs_lo), .b_chip_select_high_active(cs_hi), .b_write_n(b_wr),
    .b_lower_lane_select_n(lo_n), .b_upper_lane_select_n(hi_n), .b_output_enable_n(oe_n),
    .b_output_mode_select(mode), .b_data_in(b_din), .b_data_out(b_dout), .b_data_oe(b_oe),
    .b_powered_down(b_pd));
  b_host host (.clk(clk), .op(bop), .a(14'h0100), .d(18'h0beef), .addr(b_adr),
    .strobe_n(b_stb), .write_n(b_wr), .data(b_din));
  task automatic tick();
    @(posedge clk);
    #1;
  endtask
  task automatic step(input logic s, e, c, w, input logic [1:0] ln, input logic [13:0] a,
                      input logic [17:0] d);
    tick();
    {stb_n, en_n, clr_n, wr_n, hi_n, lo_n} = {s, e, c, w, ln};
    adr = a;
    din = d;
  endtask
  task automatic cmp_word(input string nm, input logic [17:0] exp, got);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic cmp_flag(input string nm, input logic exp, got);
    cmp_word(nm, {17'h0, exp}, {17'h0, got});
  endtask
  task automatic report_and_stop();
    $display("compared %0d fails %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    #5000;
    fails++;
    report_and_stop();
  end
  initial begin
    repeat (6) @(posedge clk);
    #1;
    cmp_flag("reset_pd", H, a_pd);
    cmp_word("reset_oe", '0, a_oe);
    rst = 1'b0;
    foreach (rows[i]) begin
      step(L, H, H, L, 2'b00, rows[i].adr, rows[i].dat);
      step(L, H, H, H, 2'b00, rows[i].adr, '0);
      tick();
      cmp_word("row_data", rows[i].dat, a_dout);
      cmp_word("row_oe", '1, a_oe);
    end
    step(L, H, H, L, 2'b00, 14'h3ffe, 18'h11111);
    step(H, L, H, L, 2'b00, 14'h0, 18'h22222);
    step(H, L, H, L, 2'b00, 14'h0, 18'h33333);
    step(L, H, H, H, 2'b00, 14'h3ffe, '0);
    tick();
    cmp_word("burst0", 18'h11111, a_dout);
    step(H, L, H, H, 2'b00, 14'h0, '0);
    tick();
    cmp_word("burst1", 18'h22222, a_dout);
    tick();
    cmp_word("burst_wrap", 18'h33333, a_dout);
    step(L, H, L, H, 2'b00, 14'h0005, '0);
    tick();
    cmp_word("clear", 18'h33333, a_dout);
    step(H, H, H, H, 2'b00, 14'h0005, '0);
    tick();
    cmp_word("hold", 18'h33333, a_dout);
    cs_lo = H;
    step(L, H, H, L, 2'b00, 14'h3fff, 18'h3c3c3);
    tick();
    cmp_flag("desel_pd", H, a_pd);
    cmp_word("desel_oe", '0, a_oe);
    {cs_lo, stb_n, wr_n} = {L, H, H};
    tick();
    cmp_word("desel_load", 18'h22222, a_dout);
    step(L, H, H, L, 2'b00, 14'h0007, 18'h2aaaa);
    step(L, H, H, L, 2'b10, 14'h0007, 18'h15555);
    step(L, H, H, H, 2'b00, 14'h0007, '0);
    repeat (2) tick();
    cmp_word("upper_lane", (18'h2aaaa & 18'h3fe00) | (18'h15555 & 18'h001ff), a_dout);
    lo_n = H;
    tick();
    cmp_word("lower_lane", 18'h3fe00, a_oe);
    oe_n = H;
    #1;
    cmp_word("oe_async", '0, a_oe);
    tick();
    {oe_n, lo_n, mode} = {L, L, H};
    step(L, H, H, H, 2'b00, 14'h3ffe, '0);
    step(L, H, H, H, 2'b00, 14'h3fff, '0);
    tick();
    cmp_word("pipe_lag", 18'h11111, a_dout);
    tick();
    cmp_word("pipe_next", 18'h22222, a_dout);
    cs_lo = H;
    tick();
    cmp_word("pipe_desel0", '1, a_oe);
    tick();
    cmp_word("pipe_desel1", '0, a_oe);
    cs_lo = L;
    tick();
    cmp_word("pipe_resel0", '0, a_oe);
    tick();
    cmp_word("pipe_resel1", '1, a_oe);
    {mode, bop} = {L, 2'd1};
    step(L, H, H, L, 2'b00, 14'h0200, 18'h1cafe);
    bop = 2'd0;
    step(L, H, H, H, 2'b00, 14'h0200, '0);
    bop = 2'd2;
    tick();
    bop = 2'd0;
    repeat (2) tick();
    cmp_word("a_both", 18'h1cafe, a_dout);
    cmp_word("b_both", 18'h0beef, b_dout);
    cmp_word("b_both_oe", '1, b_oe);
    // Mid-run reset: both counters return to zero
    rst = 1'b1;
    repeat (2) tick();
    cmp_flag("mid_reset_pd", H, a_pd);
    cmp_word("mid_reset_oe", '0, a_oe);
    {rst, stb_n} = {L, H};
    tick();
    cmp_word("mid_reset_a", 18'h33333, a_dout);
    cmp_word("mid_reset_b", 18'h33333, b_dout);
    cs_hi = L;
    tick();
    cmp_flag("desel_high_a", H, a_pd);
    cmp_flag("desel_high_b", H, b_pd);
    cmp_word("desel_high_oe", '0, a_oe);
    report_and_stop();
  end
endmodule
`default_nettype wire
